// ===== rtl/rhc_carrier.sv
// Purpose: remote carrier generator behind the gate bit
// Assumes: gate already forced low while halted
// Notes: the burst always starts with the high part of a period
`timescale 1ns/1ps
`include "rhc_defines.svh"
module rhc_carrier (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       sys_tick,
  input  wire logic [1:0] mode,
  input  wire logic       gate,
  // Pin
  output logic            remote_pin
);
  rhc_pkg::rhc_car_s q;
  rhc_pkg::rhc_car_s n;
  logic [3:0]        period;
  logic [3:0]        high;

  // Mode decode, period counter and gated output
  always_comb begin
    n = q;
    case (mode) // [R4]
      2'b00:   begin period = `RHC_CAR_P12; high = `RHC_CAR_H13; end
      2'b01:   begin period = `RHC_CAR_P8;  high = `RHC_CAR_H12; end
      2'b10:   begin period = `RHC_CAR_P12; high = `RHC_CAR_H14; end
      default: begin period = `RHC_CAR_P12; high = `RHC_CAR_P12; end
    endcase
    // Clearing on a low gate aligns each burst to its first edge
    if (!gate) begin
      n.cnt = 4'h0;
    end else if (sys_tick) begin
      n.cnt = (q.cnt == period - 4'h1) ? 4'h0 : q.cnt + 4'h1;
    end
    n.remote = gate && (q.cnt < high); // [R17]
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign remote_pin = q.remote;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_gate_off;
    !gate |=> !remote_pin;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("remote high without gate"); // [R17]

  property p_no_carrier;
    gate && mode == 2'b11 |=> remote_pin;
  endproperty
  a_no_carrier: assert property (p_no_carrier) else $error("no-carrier not following gate"); // [R17]

  property p_duty_low;
    gate && mode != 2'b11 && q.cnt >= high |=> !remote_pin;
  endproperty
  a_duty_low: assert property (p_duty_low) else $error("carrier high past duty"); // [R4]
endmodule : rhc_carrier

// ===== rtl/rhc_clk_div.sv
// Purpose: system tick and instruction-cycle tick from the oscillator clock
// Assumes: run is low while halted
// Notes: ticks are one-cycle pulses, not derived clocks
`timescale 1ns/1ps
`include "rhc_defines.svh"
module rhc_clk_div #(
  parameter bit DIVIDE8 = 1'b0
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  // Ticks
  output logic      sys_tick,
  output logic      cpu_tick
);
  rhc_pkg::rhc_div_s q;
  rhc_pkg::rhc_div_s n;

  // Prescaler then divide by six; nothing moves while halted
  always_comb begin
    n = q;
    n.sys_tick = 1'b0;
    n.cpu_tick = 1'b0;
    if (run) begin // [R6]
      if (!DIVIDE8 || q.pre == 3'(`RHC_OSC_DIV - 1)) begin // [R15]
        n.pre      = 3'h0;
        n.sys_tick = 1'b1;
        if (q.cpu == 3'(`RHC_CPU_DIV - 1)) begin // [R16]
          n.cpu      = 3'h0;
          n.cpu_tick = 1'b1;
        end else begin
          n.cpu = q.cpu + 3'h1;
        end
      end else begin
        n.pre = q.pre + 3'h1;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sys_tick = q.sys_tick;
  assign cpu_tick = q.cpu_tick;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_cpu_on_sys;
    cpu_tick |-> sys_tick;
  endproperty
  a_cpu_on_sys: assert property (p_cpu_on_sys) else $error("cpu tick off sys tick"); // [R16]
endmodule : rhc_clk_div

// ===== rtl/rhc_ctrl.sv
// Purpose: input banks, bit and nibble ports, halt, auto reset and reset sequence
// Assumes: ref_clk is the oscillator; the core drives the register port
// Notes: bus writes act only while running; reads always answer
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rhc_defines.svh"
module rhc_ctrl #(
  parameter bit          DIVIDE8    = 1'b0,
  parameter int unsigned STAB_TICKS = `RHC_STAB_TICKS,
  parameter int unsigned AUTO_TICKS = `RHC_AUTO_TICKS
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Key matrix pins
  input  wire logic [3:0] input_bank_a,
  input  wire logic [3:0] input_bank_b,
  // Output pins
  output logic            remote_pin,
  output logic      [6:1] bit_output_port,
  output logic      [3:0] nibble_output_port,
  // Status
  output logic      [3:0] input_bus,
  output logic            halted,
  output logic            cpu_tick
);
  localparam logic [12:0] STAB_LAST = 13'(STAB_TICKS - 1);
  localparam logic [16:0] AUTO_LAST = 17'(AUTO_TICKS - 1);

  rhc_pkg::rhc_top_s q;
  rhc_pkg::rhc_top_s n;
  logic              sys_tick;
  logic              cpu_tick_w;
  logic              sys_rst;
  logic              gate_rise;
  logic              halt_go;
  logic              bus_wr;
  logic [3:0]        idx;

  // Only the documented line positions may be set or cleared
  function automatic logic valid_bit(input logic [3:0] i);
    logic [13:0] m;
    m = `RHC_VALID_BITS;
    valid_bit = (i <= 4'hD) && m[i];
  endfunction : valid_bit

  // Tick generation, frozen while halted
  rhc_clk_div #(
    .DIVIDE8 (DIVIDE8)
  ) u_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .run      (q.state != rhc_pkg::rhc_st_halt),
    .sys_tick (sys_tick),
    .cpu_tick (cpu_tick_w)
  );

  // Carrier generator; the gate is dropped in halt so the pin goes low
  rhc_carrier u_car (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .sys_tick   (sys_tick),
    .mode       ({q.bit_port[`RHC_B_CSH], q.bit_port[`RHC_B_CSL]}),
    .gate       (q.bit_port[`RHC_B_GATE] && q.state != rhc_pkg::rhc_st_halt),
    .remote_pin (remote_pin)
  );

  assign idx    = reg_wdata[3:0];
  assign bus_wr = reg_wr && q.state == rhc_pkg::rhc_st_run;

  // Next-state logic of the whole control block
  always_comb begin
    n         = q;
    sys_rst   = 1'b0;
    halt_go   = 1'b0;
    n.sync1   = {input_bank_b, input_bank_a};
    n.sync2   = q.sync1;
    n.gate_d  = q.bit_port[`RHC_B_GATE];
    gate_rise = q.bit_port[`RHC_B_GATE] && !q.gate_d;

    // Shared input bus follows the bank select line
    n.in_bus = q.bit_port[`RHC_B_BANK] ? q.sync2[7:4] : q.sync2[3:0]; // [R1]

    // Operating state
    case (q.state)
      rhc_pkg::rhc_st_stab: begin
        if (sys_tick) begin
          if (q.stab_cnt >= STAB_LAST) begin // [R9]
            n.state = rhc_pkg::rhc_st_run;
          end else begin
            n.stab_cnt = q.stab_cnt + 13'h0001;
          end
        end
      end
      rhc_pkg::rhc_st_run: begin
        // Both banks must read all high, whatever the bank select
        if (q.bit_port[`RHC_B_HALT] && (&q.sync2)) begin // [R5]
          halt_go = 1'b1;
          n.state = rhc_pkg::rhc_st_halt;
        end
      end
      rhc_pkg::rhc_st_halt: begin
        // Nothing but the wake detector is alive here
        if (!(&q.sync2)) begin // [R8]
          sys_rst = 1'b1;
        end
      end
      default: begin
        sys_rst = 1'b1;
      end
    endcase

    // Auto-reset watchdog, counted in system ticks and parked in halt
    if (halt_go || gate_rise) begin // [R11]
      n.auto_cnt = 17'h00000;
    end else if (sys_tick && q.state != rhc_pkg::rhc_st_halt) begin // [R6]
      if (q.auto_cnt >= AUTO_LAST) begin // [R10]
        sys_rst = 1'b1;
      end else begin
        n.auto_cnt = q.auto_cnt + 17'h00001;
      end
    end

    // Register writes from the core
    if (bus_wr) begin
      case (reg_addr)
        `RHC_A_SET_PORT_BIT_OP: begin
          if (valid_bit(idx)) begin
            n.bit_port[idx] = 1'b1; // [R2]
          end
        end
        `RHC_A_CLEAR_PORT_BIT_OP: begin
          if (valid_bit(idx)) begin
            n.bit_port[idx] = 1'b0; // [R2]
          end
        end
        `RHC_A_NIB: begin
          n.nibble = reg_wdata[3:0]; // [R3]
        end
        `RHC_A_PAGE: begin
          n.page_buffer = reg_wdata[3:0];
        end
        `RHC_A_STAT: begin
          n.skip_flag     = reg_wdata[1];
          n.compare_latch = reg_wdata[0];
        end
        default: begin
        end
      endcase
    end

    // Program counter: one instruction per cpu tick while running
    if (q.state == rhc_pkg::rhc_st_run) begin
      if (bus_wr && reg_addr == `RHC_A_JUMP) begin
        n.page_address    = q.page_buffer;
        n.program_counter = reg_wdata[5:0];
      end else if (cpu_tick_w) begin
        if (q.pc_clear) begin
          n.program_counter = 6'h00; // [R12]
          n.pc_clear        = 1'b0;
        end else begin
          n.program_counter = q.program_counter + 6'h01;
        end
      end
    end

    // System reset from wake, watchdog or a bad state
    if (sys_rst) begin // [R18]
      n.state         = rhc_pkg::rhc_st_stab;
      n.stab_cnt      = 13'h0000;
      n.auto_cnt      = 17'h00000;
      n.page_address  = `RHC_PAGE_RST; // [R12]
      n.pc_clear      = 1'b1;
      n.page_buffer   = `RHC_PAGE_RST; // [R13]
      n.skip_flag     = 1'b1;
      n.compare_latch = 1'b1;
      // RAM pointer is left untouched by design and is not held here [R13]
      n.bit_port      = 14'h0000; // [R14]
      n.nibble        = 4'h0;
    end

    // Pins follow the next port values; halt masks all but lines one and six
    if (n.state == rhc_pkg::rhc_st_halt) begin // [R7]
      n.bit_pins = {n.bit_port[`RHC_B_KEEP6], 4'h0, n.bit_port[`RHC_B_KEEP1]};
      n.nib_pins = 4'h0;
    end else begin
      n.bit_pins = n.bit_port[6:1];
      n.nib_pins = n.nibble;
    end

    // Read data stands for one cycle only
    n.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RHC_A_SET_PORT_BIT_OP:  n.rdata = q.bit_port[7:0];
        `RHC_A_CLEAR_PORT_BIT_OP:  n.rdata = {2'h0, q.bit_port[13:8]};
        `RHC_A_NIB:   n.rdata = {4'h0, q.nibble};
        `RHC_A_PAGE:  n.rdata = {q.page_buffer, q.page_address};
        `RHC_A_JUMP:  n.rdata = {2'h0, q.program_counter};
        `RHC_A_INBUS: n.rdata = {4'h0, q.in_bus};
        `RHC_A_STAT:  n.rdata = {q.pc_clear, 2'h0, q.state, q.skip_flag, q.compare_latch};
        default:      n.rdata = 8'h00;
      endcase
    end
  end

  // State register; power-on reset gives the same initial picture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q                 <= '0;
      q.state           <= rhc_pkg::rhc_st_stab; // [R9]
      q.page_address    <= `RHC_PAGE_RST;
      q.page_buffer     <= `RHC_PAGE_RST;
      q.pc_clear        <= 1'b1;
      q.skip_flag       <= 1'b1;
      q.compare_latch   <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Output drive, all from registers
  assign reg_rdata          = q.rdata;
  assign bit_output_port    = q.bit_pins;
  assign nibble_output_port = q.nib_pins;
  assign input_bus          = q.in_bus;
  assign halted             = q.state[2]; // One-hot halt bit, straight from the flop
  assign cpu_tick           = cpu_tick_w;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_bank_route;
    1'b1 |=> input_bus == ($past(q.bit_port[13]) ? $past(q.sync2[7:4]) : $past(q.sync2[3:0]));
  endproperty
  a_bank_route: assert property (p_bank_route) else $error("input bus not routed"); // [R1]

  property p_set_bit;
    bus_wr && reg_addr == `RHC_A_SET_PORT_BIT_OP && valid_bit(idx) && !sys_rst
      |=> q.bit_port[$past(idx)];
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("set bit lost"); // [R2]

  property p_clr_bit;
    bus_wr && reg_addr == `RHC_A_CLEAR_PORT_BIT_OP && valid_bit(idx) && !sys_rst |=> !q.bit_port[$past(idx)];
  endproperty
  a_clr_bit: assert property (p_clr_bit) else $error("clear bit lost"); // [R2]

  property p_nibble;
    bus_wr && reg_addr == `RHC_A_NIB && !sys_rst && !halt_go
      |=> nibble_output_port == $past(reg_wdata[3:0]);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble pins wrong"); // [R3]

  property p_halt_entry;
    q.state == rhc_pkg::rhc_st_run && q.bit_port[12] && (&q.sync2) |=> halted;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt not entered"); // [R5]

  property p_no_halt;
    q.state == rhc_pkg::rhc_st_run && !(&q.sync2) |=> !halted;
  endproperty
  a_no_halt: assert property (p_no_halt) else $error("halt without idle inputs"); // [R5]

  property p_frozen;
    halted ##1 halted |-> $stable(q.auto_cnt) && $stable(q.program_counter) && !sys_tick;
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved in halt"); // [R6]

  property p_halt_pins;
    halted |-> nibble_output_port == 4'h0 && bit_output_port[5:2] == 4'h0
      && bit_output_port[6] == q.bit_port[6] && bit_output_port[1] == q.bit_port[1];
  endproperty
  a_halt_pins: assert property (p_halt_pins) else $error("halt pin levels wrong"); // [R7]

  sequence s_wake_req;
    halted && !(&q.sync2);
  endsequence
  sequence s_reset_pic;
    q.state == rhc_pkg::rhc_st_stab && q.page_address == 4'hF && q.pc_clear
      && q.bit_port == 14'h0000 && q.skip_flag && q.compare_latch;
  endsequence
  property p_wake;
    s_wake_req |=> s_reset_pic;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without reset"); // [R8]

  property p_stab_done;
    $rose(q.state == rhc_pkg::rhc_st_run) |-> $past(q.stab_cnt) >= STAB_LAST;
  endproperty
  a_stab_done: assert property (p_stab_done) else $error("run before stabilised"); // [R9]

  property p_auto_fire;
    sys_tick && q.auto_cnt >= AUTO_LAST && q.state != rhc_pkg::rhc_st_halt
      && !halt_go && !gate_rise
      |=> q.state == rhc_pkg::rhc_st_stab && q.auto_cnt == 17'h00000;
  endproperty
  a_auto_fire: assert property (p_auto_fire) else $error("auto reset missed"); // [R10]

  property p_auto_clear;
    gate_rise |=> q.auto_cnt == 17'h00000;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("gate edge did not clear"); // [R11]

  property p_pc_clear;
    q.state == rhc_pkg::rhc_st_run && q.pc_clear && cpu_tick_w && !bus_wr && !sys_rst
      |=> q.program_counter == 6'h00 && !q.pc_clear;
  endproperty
  a_pc_clear: assert property (p_pc_clear) else $error("delayed pc clear wrong"); // [R12]
endmodule : rhc_ctrl

// ===== rtl/rhc_defines.svh
// Purpose: constants of the remote I/O halt and reset control block
// Assumes: ref_clk is the oscillator clock; times are counted in system clock ticks
// Notes: register offsets are indices on the plain register port
// How it works
// R1: bank select low reads A, high B
// R2: set/clear one addressed bit-port line
// R3: nibble write copies whole accumulator to pins
// R4: two select bits pick carrier period, duty
// R5: halt needs request bit and all inputs high
// R6: halted freezes ticks, counters and state; carrier count held at zero, input bus still follows keys
// R7: halted pins low except lines one, six
// R8: any input low wakes with system reset
// R9: wait stabilisation time before execution resumes
// R10: auto reset after full count without clear
// R11: gate rise, halt or power-on clear counter
// R12: page F now, counter clears one cycle later
// R13: page buffer F, skip and latch set
// R14: reset drives all port lines low
// R15: system clock is oscillator or divided eight
// R16: instruction cycle is six system clocks
// R17: remote pin carries carrier only while gated
// R18: wake-up does the full reset sequence
`ifndef RHC_DEFINES_SVH
`define RHC_DEFINES_SVH
// Register port offsets
`define RHC_A_SET_PORT_BIT_OP     4'h0
`define RHC_A_CLEAR_PORT_BIT_OP     4'h1
`define RHC_A_NIB      4'h2
`define RHC_A_PAGE     4'h3
`define RHC_A_JUMP     4'h4
`define RHC_A_INBUS    4'h5
`define RHC_A_STAT     4'h6
// Bit-port line positions
`define RHC_B_GATE     0
`define RHC_B_KEEP1    1
`define RHC_B_KEEP6    6
`define RHC_B_CSL      9
`define RHC_B_CSH      10
`define RHC_B_HALT     12
`define RHC_B_BANK     13
`define RHC_VALID_BITS 14'h367F
// Reset values
`define RHC_PAGE_RST   4'hF
// Timing
`define RHC_STAB_US    13000
`define RHC_REF_KHZ    455
`define RHC_STAB_TICKS ((`RHC_STAB_US * `RHC_REF_KHZ) / 1000)
`define RHC_AUTO_TICKS 131072
`define RHC_OSC_DIV    8
`define RHC_CPU_DIV    6
// Carrier shapes: period and high time in system ticks
`define RHC_CAR_P12    4'hC
`define RHC_CAR_P8     4'h8
`define RHC_CAR_H13    4'h4
`define RHC_CAR_H12    4'h4
`define RHC_CAR_H14    4'h3
`endif

// ===== rtl/rhc_pkg.sv
// Purpose: types of the remote I/O halt and reset control block
// Assumes: constants live in rhc_defines.svh
// Notes: one state struct per module
package rhc_pkg;
  typedef enum logic [2:0] {
    rhc_st_stab = 3'b001,
    rhc_st_run  = 3'b010,
    rhc_st_halt = 3'b100
  } rhc_state_e;

  typedef struct packed {
    logic [2:0] pre;
    logic [2:0] cpu;
    logic       sys_tick;
    logic       cpu_tick;
  } rhc_div_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic       remote;
  } rhc_car_s;

  typedef struct packed {
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    rhc_state_e  state;
    logic [13:0] bit_port;
    logic [3:0]  nibble;
    logic [3:0]  page_address;
    logic [3:0]  page_buffer;
    logic [5:0]  program_counter;
    logic        pc_clear;
    logic        skip_flag;
    logic        compare_latch;
    logic [12:0] stab_cnt;
    logic [16:0] auto_cnt;
    logic        gate_d;
    logic [3:0]  in_bus;
    logic [6:1]  bit_pins;
    logic [3:0]  nib_pins;
    logic [7:0]  rdata;
  } rhc_top_s;
endpackage : rhc_pkg

// ===== verif/rhc_ctrl_test.sv
// Purpose: self-checking bench of the halt, reset and port control block
// Assumes: DIVIDE8 0 gives one system tick per ref_clk; STAB and AUTO shortened
// Notes: the second instance only shows the divided instruction tick
`timescale 1ns/1ps
`include "rhc_defines.svh"
module remote_io_halt_reset_control_test;
  localparam int unsigned STAB = 20;
  localparam int unsigned AUTO = 400;
  logic        ref_clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [3:0]  input_bank_a;
  logic [3:0]  input_bank_b;
  logic        remote_pin;
  logic [6:1]  bit_output_port;
  logic [3:0]  nibble_output_port;
  logic [3:0]  input_bus;
  logic        halted;
  logic        cpu_tick;
  logic        cpu_tick8;
  logic [7:0]  keys_down;
  logic        count_clear;
  int          ir_highs;
  int          err_count;
  int          checks;
  int          seed;
  int          n;
  int          r;
  logic [7:0]  d;
  logic [7:0]  e;
  logic [13:0] bp;

  rhc_ctrl #(.DIVIDE8(1'b0), .STAB_TICKS(STAB), .AUTO_TICKS(AUTO)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_bank_a(input_bank_a),
    .input_bank_b(input_bank_b), .remote_pin(remote_pin), .bit_output_port(bit_output_port),
    .nibble_output_port(nibble_output_port), .input_bus(input_bus), .halted(halted),
    .cpu_tick(cpu_tick));
  rhc_ctrl #(.DIVIDE8(1'b1), .STAB_TICKS(STAB), .AUTO_TICKS(AUTO)) DUT8 (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .input_bank_a(input_bank_a),
    .input_bank_b(input_bank_b), .remote_pin(), .bit_output_port(),
    .nibble_output_port(), .input_bus(), .halted(), .cpu_tick(cpu_tick8));
  rhc_key_model KEYS (
    .ref_clk(ref_clk), .keys_down(keys_down), .count_clear(count_clear),
    .ir_highs(ir_highs), .input_bank_a(input_bank_a), .input_bank_b(input_bank_b),
    .remote_pin(remote_pin));

  // Free-running oscillator clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // High cycles in a 24-cycle window: two periods of 12 or three of 8
  function automatic int car_highs(input logic [1:0] m);
    case (m)
      2'b00:   return 8;
      2'b01:   return 12;
      2'b10:   return 6;
      default: return 24;
    endcase
  endfunction : car_highs

  // Lines that the set and clear operations may address
  function automatic logic idx_ok(input int i);
    return (i <= 6) || (i == 9) || (i == 10) || (i == 12) || (i == 13);
  endfunction : idx_ok

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus cycles; a spare cycle keeps a strobe from being driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
    @(posedge ref_clk);
  endtask : rd

  task automatic pb(input logic s, input logic [3:0] i);
    wr(s ? `RHC_A_SET_PORT_BIT_OP : `RHC_A_CLEAR_PORT_BIT_OP, {4'h0, i});
  endtask : pb

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("ports in reset", 16'h0, {remote_pin, bit_output_port, nibble_output_port});
    rst_n <= 1'b1;
  endtask : do_reset

  // Polls the state field until run, counting cycles spent
  task automatic wait_run(output int c);
    c = 0;
    d = 8'h00;
    while (d[4:2] !== 3'b010 && c < 200) begin
      rd(`RHC_A_STAT, d);
      c += 2;
    end
  endtask : wait_run

  task automatic wait_halt(input logic v);
    for (int k = 0; k < 10 && halted !== v; k++) @(negedge ref_clk);
    @(posedge ref_clk);
    chk("halted", v, halted);
  endtask : wait_halt

  task automatic tick_gap(input logic slow, output int c);
    c = 0;
    repeat (100) begin
      @(negedge ref_clk);
      if ((slow ? cpu_tick8 : cpu_tick) === 1'b1) break;
    end
    do begin
      @(negedge ref_clk);
      c++;
    end while ((slow ? cpu_tick8 : cpu_tick) !== 1'b1 && c < 100);
    @(posedge ref_clk);
  endtask : tick_gap

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    close_out();
  end

  // Main sequence
  initial begin
    seed = 53;
    err_count = 0;
    checks = 0;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    keys_down = 8'h00;
    count_clear = 1'b0;
    do_reset();
    rd(`RHC_A_STAT, d);
    chk("state after reset", 8'h07, d & 8'h1F);
    rd(`RHC_A_PAGE, d);
    chk("page after reset", 8'hFF, d);
    wait_run(n);
    chk("stabilise wait", 1, n + 4 >= STAB && n + 4 <= STAB + 10);
    tick_gap(1'b0, n);
    chk("instruction cycle", 6, n);
    tick_gap(1'b1, n);
    chk("divided instruction cycle", 48, n);
    $display("test reset done");
    // Random keys, bank select toggled each pass
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      keys_down <= r[7:0];
      pb(i[0], 4'hD);
      repeat (4) @(posedge ref_clk);
      rd(`RHC_A_INBUS, d);
      chk("input bus", {4'h0, i[0] ? ~r[7:4] : ~r[3:0]}, d);
      chk("input bus pins", {4'h0, i[0] ? ~r[7:4] : ~r[3:0]}, input_bus);
    end
    $display("test banks done");
    // Random set and clear, unaddressable lines among them; a held key refuses halt
    do_reset();
    wait_run(n);
    keys_down <= 8'h10;
    bp = 14'h0;
    for (int i = 0; i < 14; i++) begin
      r = $random(seed);
      pb(r[4], r[3:0]);
      if (idx_ok(r[3:0])) bp[r[3:0]] = r[4];
      rd(`RHC_A_SET_PORT_BIT_OP, d);
      chk("bit port low", bp[7:0], d);
      rd(`RHC_A_CLEAR_PORT_BIT_OP, d);
      chk("bit port high", {2'b00, bp[13:8]}, d);
      chk("bit pins", bp[6:1], bit_output_port);
    end
    pb(1'b1, 4'hC);
    repeat (6) @(posedge ref_clk);
    chk("halt with key held", 0, halted);
    $display("test bits done");
    // Nibble follows the value whatever the compare latch holds
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      wr(`RHC_A_STAT, {6'h00, 1'b1, r[4]});
      wr(`RHC_A_NIB, {4'h0, r[3:0]});
      chk("nibble pins", r[3:0], nibble_output_port);
    end
    // Page buffer moves to the page address on a jump
    wr(`RHC_A_PAGE, 8'h03);
    wr(`RHC_A_JUMP, 8'h2A);
    rd(`RHC_A_PAGE, d);
    chk("page after jump", 8'h33, d);
    rd(`RHC_A_JUMP, d);
    chk("counter after jump", 1, d == 8'h2A || d == 8'h2B);
    $display("test nibble done");
    // Every carrier mode, gated on and off
    for (int m = 0; m < 4; m++) begin
      pb(m[0], 4'h9);
      pb(m[1], 4'hA);
      pb(1'b1, 4'h0);
      repeat (30) @(posedge ref_clk);
      count_clear <= 1'b1;
      @(posedge ref_clk);
      count_clear <= 1'b0;
      repeat (24) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("carrier highs", car_highs(m[1:0]), ir_highs);
      pb(1'b0, 4'h0);
      repeat (3) @(posedge ref_clk);
      chk("remote when ungated", 0, remote_pin);
    end
    // Gate rises keep the auto-reset count from expiring
    repeat (3) begin
      pb(1'b1, 4'h0);
      pb(1'b0, 4'h0);
      repeat (300) @(posedge ref_clk);
    end
    rd(`RHC_A_STAT, d);
    chk("run kept by gate", 3'b010, d[4:2]);
    // A hidden auto reset would have cleared the carrier mode lines
    rd(`RHC_A_CLEAR_PORT_BIT_OP, d);
    chk("mode kept by gate", 2'b11, d[2:1]);
    $display("test carrier done");
    // Auto reset with no gate rise
    do_reset();
    wait_run(n);
    wr(`RHC_A_NIB, 8'h05);
    repeat (AUTO - 60) @(posedge ref_clk);
    chk("nibble before auto reset", 4'h5, nibble_output_port);
    n = 0;
    while (nibble_output_port !== 4'h0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk("auto reset moment", 1, n > 10 && n < 100);
    $display("test auto reset done");
    // Halt refused, entered, held past the auto count, then woken
    do_reset();
    wait_run(n);
    keys_down <= 8'h01;
    pb(1'b1, 4'h1);
    pb(1'b1, 4'h2);
    pb(1'b1, 4'h6);
    wr(`RHC_A_NIB, 8'h0F);
    pb(1'b1, 4'hC);
    repeat (6) @(posedge ref_clk);
    chk("halt with key held", 0, halted);
    keys_down <= 8'h00;
    wait_halt(1'b1);
    chk("nibble in halt", 4'h0, nibble_output_port);
    chk("bit lines in halt", 6'h21, bit_output_port);
    rd(`RHC_A_JUMP, e);
    repeat (AUTO + 50) @(posedge ref_clk);
    rd(`RHC_A_JUMP, d);
    chk("counter in halt", e, d);
    chk("no auto reset in halt", 1, halted);
    r = $random(seed);
    keys_down <= 8'h01 << r[2:0];
    wait_halt(1'b0);
    chk("bit lines after wake", 6'h00, bit_output_port);
    rd(`RHC_A_STAT, d);
    chk("state after wake", 8'h07, d & 8'h1F);
    wait_run(n);
    rd(`RHC_A_PAGE, d);
    chk("page after wake", 8'hFF, d);
    $display("test halt done");
    close_out();
  end
endmodule : remote_io_halt_reset_control_test

// ===== verif/rhc_key_model.sv
// Purpose: key matrix and infrared driver that face the control block
// Assumes: a released key reads high through its pull-up
// Notes: the driver load only counts the high cycles of the remote pin
`timescale 1ns/1ps
module rhc_key_model (
  // Clock
  input  wire logic       ref_clk,
  // Bench side
  input  wire logic [7:0] keys_down,
  input  wire logic       count_clear,
  output int              ir_highs,
  // Key pins
  output logic      [3:0] input_bank_a,
  output logic      [3:0] input_bank_b,
  // Remote pin load
  input  wire logic       remote_pin
);
  // A pressed key pulls its line low, which is also how halt is left
  assign input_bank_a = ~keys_down[3:0];
  assign input_bank_b = ~keys_down[7:4];

  // High cycles seen since the last clear; unknown levels never count
  always_ff @(posedge ref_clk) begin
    if (count_clear) begin
      ir_highs <= 0;
    end else if (remote_pin === 1'b1) begin
      ir_highs <= ir_highs + 1;
    end
  end
endmodule : rhc_key_model
